// ---- design/outprot_pkg.sv ----
package outprot_pkg;
   // ==========================================================
   // Bus and clock
   // ==========================================================
   localparam int PADDR_W = 12;
   localparam int CLK_FREQ_HZ = 25_000_000;
   localparam int DEB_TICK_US = 1000;
   localparam int DEB_TICK_CYCLES = DEB_TICK_US * (CLK_FREQ_HZ / 1_000_000);

   // ==========================================================
   // Register indices (byte address is four times the index)
   // ==========================================================
   localparam logic [9:0] IDX_HS_STATUS = 10'h00d;
   localparam logic [9:0] IDX_OUT_CFG = 10'h00e;
   localparam logic [9:0] IDX_JACK_CFG = 10'h025;
   localparam logic [9:0] IDX_SP_CFG = 10'h026;
   localparam logic [9:0] IDX_SC_STATUS = 10'h05f;
   localparam logic [9:0] IDX_INT_STATUS = 10'h060;
   localparam logic [9:0] IDX_INT_MASK = 10'h061;
   localparam logic [9:0] IDX_DRV_POWER = 10'h062;
   localparam logic [9:0] IDX_VOL_BASE = 10'h063;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int HS_DET_EN_BIT = 7;
   localparam int HS_TYPE_LSB = 5;
   localparam int HS_PLUG_BIT = 4;
   localparam int HS_UNREL_BIT = 3;
   localparam int OC_MODE_LSB = 6;
   localparam int JC_DEB_LSB = 0;
   localparam int SP_DET_EN_BIT = 2;
   localparam int SP_AUTO_OFF_BIT = 1;
   localparam int SC_LATCH_LSB = 4;
   localparam int EV_SHORT = 0;
   localparam int EV_SHUTDOWN = 1;
   localparam int EV_INSERT = 2;
   localparam int EV_REMOVE = 3;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] OUT_CFG_RST = 8'h00;
   localparam logic [7:0] JACK_CFG_RST = 8'h04;
   localparam logic [7:0] SP_CFG_RST = 8'h04;
   localparam logic [3:0] INT_MASK_RST = 4'h0;
   localparam logic [6:0] VOL_RST = 7'h00;

   // ==========================================================
   // Output wiring modes and headset types
   // ==========================================================
   typedef enum logic [1:0] {
      OUT_CAPLESS = 2'b00,
      OUT_AC_COUPLED = 2'b01,
      OUT_FULL_DIFF = 2'b10,
      OUT_RESERVED = 2'b11
   } out_mode_t;

   typedef enum logic [1:0] {
      HS_NONE = 2'b00,
      HS_STEREO = 2'b01,
      HS_MONO = 2'b10,
      HS_WITH_MIC = 2'b11
   } hs_type_t;

   // ==========================================================
   // Volume code segments (attenuation in 0.1 dB units)
   // ==========================================================
   localparam logic [6:0] VOL_SEG1_END = 7'h24;
   localparam logic [6:0] VOL_SEG2_END = 7'h46;
   localparam logic [6:0] VOL_SEG3_BEG = 7'h4c;
   localparam logic [6:0] VOL_SEG3_END = 7'h56;
   localparam logic [6:0] VOL_MUTE_MIN = 7'h76;
endpackage

// ---- design/gain_lookup_if.sv ----
`timescale 1ns/1ps
interface gain_lookup_if;
   logic [6:0] code;
   logic [9:0] atten;
   logic mute;

   modport requester (output code, input atten, input mute);
   modport table_side (input code, output atten, output mute);
endinterface

// ---- design/gain_lookup.sv ----
`timescale 1ns/1ps
module gain_lookup
   import outprot_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   gain_lookup_if.table_side tbl
);

   typedef struct packed {
      logic [9:0] atten;
      logic mute;
   } lk_state_t;

   lk_state_t st_r;
   lk_state_t st_nxt;

   // ==========================================================
   // Code to attenuation, 0.1 dB units
   // ==========================================================
   function automatic logic [9:0] atten_of(input logic [6:0] c);
      logic [9:0] x5;
      logic [9:0] a;
      x5 = 10'({3'h0, c}) * 10'h005;
      a = 10'h000;
      if (c <= VOL_SEG1_END) begin
         a = x5;
      end else if (c <= VOL_SEG2_END) begin
         a = x5 + 10'h001;
      end else if (c >= VOL_SEG3_BEG && c <= VOL_SEG3_END) begin
         a = x5 + 10'h002;
      end else begin
         // Irregular steps between the linear segments and near the bottom of the range
         unique case (c)
            7'h47: a = 10'h165;
            7'h48: a = 10'h169;
            7'h49: a = 10'h16f;
            7'h4a: a = 10'h173;
            7'h4b: a = 10'h179;
            7'h57: a = 10'h1b6;
            7'h58: a = 10'h1bb;
            7'h59: a = 10'h1c0;
            7'h5a: a = 10'h1c4;
            7'h5b: a = 10'h1ca;
            7'h5c: a = 10'h1ce;
            7'h5d: a = 10'h1d3;
            7'h5e: a = 10'h1da;
            7'h5f: a = 10'h1df;
            7'h60: a = 10'h1e2;
            7'h61: a = 10'h1e7;
            7'h62: a = 10'h1ed;
            7'h63: a = 10'h1f4;
            7'h64: a = 10'h1f7;
            7'h65: a = 10'h1fe;
            7'h66: a = 10'h202;
            7'h67: a = 10'h206;
            7'h68: a = 10'h20a;
            7'h69: a = 10'h20f;
            7'h6a: a = 10'h219;
            7'h6b: a = 10'h21e;
            7'h6c: a = 10'h229;
            7'h6d: a = 10'h237;
            7'h6e: a = 10'h247;
            7'h6f: a = 10'h25a;
            7'h70: a = 10'h273;
            7'h71: a = 10'h283;
            7'h72: a = 10'h296;
            7'h73: a = 10'h2af;
            7'h74: a = 10'h2d2;
            7'h75: a = 10'h30f;
            default: a = 10'h000; // Mute codes carry no level
         endcase
      end
      return a;
   endfunction

   // Next lookup result
   always_comb begin
      st_nxt = st_r;
      st_nxt.mute = (tbl.code >= VOL_MUTE_MIN);
      st_nxt.atten = atten_of(tbl.code);
   end

   // Read data always come from a register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tbl.atten = st_r.atten;
   assign tbl.mute = st_r.mute;
endmodule

// ---- design/output_protect_detect_volume.sv ----
// Operation
// - Shorted driver limits current, stays powered
// - Status register shows drivers in protection
// - Auto mode powers shorted driver down
// - Shutdown holds until power down, then up
// - Debounced jack monitor classifies plug type
// - Detected headset type read from status
// - AC-coupled mono/stereo result flagged unreliable
// - Volume 0 to -78.3 dB plus mute
// - Code 0 is 0 dB; 118-127 mute
// - Seven independent volume controls
`timescale 1ns/1ps
module output_protect_detect_volume
   import outprot_pkg::*;
#(
   parameter int NDRV = 4,
   parameter int NVOL = 7,
   parameter int TICK_CYCLES = DEB_TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NDRV-1:0] short_det,
   output logic [NDRV-1:0] drv_power_on,
   output logic [NDRV-1:0] drv_limit,
   input wire logic jack_sense,
   input wire logic mic_sense,
   input wire logic mono_sense,
   output logic [NVOL*10-1:0] vol_atten,
   output logic [NVOL-1:0] vol_mute,
   output logic irq
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (NDRV < 1 || NDRV > 4) begin : g_bad_ndrv
      $error("NDRV must be 1 to 4");
   end
   if (NVOL < 1 || NVOL > 7) begin : g_bad_nvol
      $error("NVOL must be 1 to 7");
   end
   if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
      $error("TICK_CYCLES must be 1 to 65535");
   end

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
   localparam logic [2:0] SCAN_LAST = 3'(NVOL - 1);

   typedef struct packed {
      logic detect_en;
      logic [7:0] out_cfg;
      logic [7:0] jack_cfg;
      logic [7:0] sp_cfg;
      logic [NDRV-1:0] pwr_req;
      logic [NDRV-1:0] shut_lat;
      logic [NDRV-1:0] limit;
      logic [NDRV-1:0] drv_on;
      logic [3:0] int_stat;
      logic [3:0] int_mask;
      logic irq;
      logic [NVOL-1:0][6:0] vol_code;
      logic [NVOL-1:0][9:0] atten;
      logic [NVOL-1:0] mute;
      logic [2:0] scan_idx;
      logic [2:0] scan_prev;
      logic scan_vld;
      logic [15:0] tick_cnt;
      logic [3:0] deb_cnt;
      logic plug;
      logic [1:0] hs_type;
      logic unreliable;
      logic [31:0] prdata;
   } core_state_t;

   core_state_t st_r;
   core_state_t st_nxt;
   gain_lookup_if lk ();

   logic [9:0] idx;
   logic vol_hit;
   logic [2:0] vol_sel;
   logic hit;
   logic setup_rd;
   logic acc_wr;
   logic acc_rd;
   logic tick;
   logic [7:0] rd_val;
   logic [3:0] ev;
   logic prot;

   // ==========================================================
   // APB decode
   // ==========================================================
   // Zero wait states: every access phase ends in one cycle
   assign idx = paddr[PADDR_W-1:2];
   assign vol_hit = (idx >= IDX_VOL_BASE) &&
                    (idx < IDX_VOL_BASE + 10'(NVOL));
   assign vol_sel = 3'(idx - IDX_VOL_BASE);
   assign hit = vol_hit || idx == IDX_HS_STATUS || idx == IDX_OUT_CFG ||
                idx == IDX_JACK_CFG || idx == IDX_SP_CFG ||
                idx == IDX_SC_STATUS || idx == IDX_INT_STATUS ||
                idx == IDX_INT_MASK || idx == IDX_DRV_POWER;
   assign setup_rd = psel && !penable && !pwrite;
   assign acc_wr = psel && penable && pwrite && hit;
   assign acc_rd = psel && penable && !pwrite && hit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign tick = (st_r.tick_cnt == TICK_LAST);

   // Read multiplexer, sampled in the setup cycle
   always_comb begin
      rd_val = 8'h00;
      if (vol_hit) begin
         rd_val = {1'b0, st_r.vol_code[vol_sel]};
      end else begin
         unique case (idx)
            IDX_HS_STATUS: begin
               rd_val[HS_DET_EN_BIT] = st_r.detect_en;
               rd_val[HS_TYPE_LSB +: 2] = st_r.hs_type;
               rd_val[HS_PLUG_BIT] = st_r.plug;
               rd_val[HS_UNREL_BIT] = st_r.unreliable;
            end
            IDX_OUT_CFG: rd_val = st_r.out_cfg;
            IDX_JACK_CFG: rd_val = st_r.jack_cfg;
            IDX_SP_CFG: rd_val = st_r.sp_cfg;
            IDX_SC_STATUS: begin
               rd_val[NDRV-1:0] = st_r.limit;
               rd_val[SC_LATCH_LSB +: NDRV] = st_r.shut_lat;
            end
            IDX_INT_STATUS: rd_val[3:0] = st_r.int_stat;
            IDX_INT_MASK: rd_val[3:0] = st_r.int_mask;
            IDX_DRV_POWER: rd_val[NDRV-1:0] = st_r.pwr_req;
            default: rd_val = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_nxt = st_r;
      ev = 4'h0;
      prot = 1'b0;

      // Register writes take effect in the access phase
      if (acc_wr) begin
         if (vol_hit) begin
            st_nxt.vol_code[vol_sel] = pwdata[6:0];
         end else begin
            unique case (idx)
               IDX_HS_STATUS: st_nxt.detect_en = pwdata[HS_DET_EN_BIT];
               IDX_OUT_CFG: st_nxt.out_cfg = pwdata[7:0];
               IDX_JACK_CFG: st_nxt.jack_cfg = pwdata[7:0];
               IDX_SP_CFG: st_nxt.sp_cfg = pwdata[7:0];
               IDX_INT_MASK: st_nxt.int_mask = pwdata[3:0];
               IDX_DRV_POWER: begin
                  st_nxt.pwr_req = pwdata[NDRV-1:0];
                  // Powering a driver down releases its latch
                  st_nxt.shut_lat = st_r.shut_lat & pwdata[NDRV-1:0];
               end
               default: st_nxt.detect_en = st_r.detect_en;
            endcase
         end
      end

      // Read data latched in setup so the access phase sees it stable
      if (setup_rd) begin
         st_nxt.prdata = {24'h000000, rd_val};
      end

      // Short protection per driver; a new short beats a same-cycle clear
      for (int i = 0; i < NDRV; i++) begin
         prot = short_det[i] && st_r.drv_on[i] &&
                st_r.sp_cfg[SP_DET_EN_BIT];
         st_nxt.limit[i] = prot;
         if (prot && !st_r.limit[i]) begin
            ev[EV_SHORT] = 1'b1;
         end
         if (prot && st_r.sp_cfg[SP_AUTO_OFF_BIT]) begin
            st_nxt.shut_lat[i] = 1'b1;
            if (!st_r.shut_lat[i]) begin
               ev[EV_SHUTDOWN] = 1'b1;
            end
         end
      end
      // Driver stays off while latched, whatever was requested
      st_nxt.drv_on = st_nxt.pwr_req & ~st_nxt.shut_lat;

      // Debounce tick divider
      st_nxt.tick_cnt = tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;

      // Plug debounce: level must hold for the programmed tick count plus one
      if (!st_r.detect_en) begin
         st_nxt.plug = 1'b0;
         st_nxt.deb_cnt = 4'h0;
      end else if (jack_sense == st_r.plug) begin
         st_nxt.deb_cnt = 4'h0;
      end else if (tick) begin
         if (st_r.deb_cnt == st_r.jack_cfg[JC_DEB_LSB +: 4]) begin
            st_nxt.plug = jack_sense;
            st_nxt.deb_cnt = 4'h0;
         end else begin
            st_nxt.deb_cnt = st_r.deb_cnt + 4'h1;
         end
      end
      ev[EV_INSERT] = st_nxt.plug && !st_r.plug;
      ev[EV_REMOVE] = !st_nxt.plug && st_r.plug;

      // Classify the plug while it is present
      if (!st_nxt.plug) begin
         st_nxt.hs_type = HS_NONE;
      end else if (mic_sense) begin
         st_nxt.hs_type = HS_WITH_MIC;
      end else if (mono_sense) begin
         st_nxt.hs_type = HS_MONO;
      end else begin
         st_nxt.hs_type = HS_STEREO;
      end
      // Coupling caps hide the mono/stereo difference
      st_nxt.unreliable = st_nxt.plug &&
         (st_r.out_cfg[OC_MODE_LSB +: 2] == OUT_AC_COUPLED);

      // Sticky events: clear by read, but a new event wins
      if (acc_rd && idx == IDX_INT_STATUS) begin
         st_nxt.int_stat = st_r.int_stat & ~st_r.prdata[3:0];
      end
      st_nxt.int_stat = st_nxt.int_stat | ev;
      st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);

      // Round-robin through the volume controls via the shared table
      st_nxt.scan_prev = st_r.scan_idx;
      st_nxt.scan_vld = 1'b1;
      st_nxt.scan_idx = (st_r.scan_idx == SCAN_LAST) ?
                        3'h0 : st_r.scan_idx + 3'h1;
      if (st_r.scan_vld) begin
         st_nxt.atten[st_r.scan_prev] = lk.atten;
         st_nxt.mute[st_r.scan_prev] = lk.mute;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.out_cfg <= OUT_CFG_RST;
         st_r.jack_cfg <= JACK_CFG_RST;
         st_r.sp_cfg <= SP_CFG_RST;
         st_r.int_mask <= INT_MASK_RST;
         st_r.vol_code <= {NVOL{VOL_RST}};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Gain table and outputs
   // ==========================================================
   // One shared table instead of seven: a control settles within NVOL+1 cycles
   assign lk.code = st_r.vol_code[st_r.scan_idx];

   gain_lookup u_gain_lookup (
      .pclk(pclk),
      .presetn(presetn),
      .tbl(lk)
   );

   assign prdata = st_r.prdata;
   assign drv_power_on = st_r.drv_on;
   assign drv_limit = st_r.limit;
   assign vol_atten = st_r.atten;
   assign vol_mute = st_r.mute;
   assign irq = st_r.irq;
endmodule

// ---- testbench/outprot_checker.sv ----
`timescale 1ns/1ps
module outprot_checker
   import outprot_pkg::*;
#(
   parameter int NDRV = 4,
   parameter int NVOL = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NDRV-1:0] short_det,
   input wire logic [NDRV-1:0] drv_power_on,
   input wire logic [NDRV-1:0] drv_limit,
   input wire logic [NVOL*10-1:0] vol_atten,
   input wire logic [NVOL-1:0] vol_mute,
   input wire logic irq
);
   // ==========================================
   // Helper logic
   // ==========================================
   logic [1:0] sp_r;
   logic acc;
   logic hit;
   logic ireg;
   logic [9:0] idx;
   assign idx = paddr[11:2];
   assign acc = psel & penable & pready;
   assign ireg = psel && (idx == IDX_INT_STATUS || idx == IDX_INT_MASK);
   assign hit = (idx inside {IDX_HS_STATUS, IDX_OUT_CFG, IDX_JACK_CFG,
      IDX_SP_CFG, IDX_SC_STATUS, IDX_INT_STATUS, IDX_INT_MASK,
      IDX_DRV_POWER}) || (idx >= IDX_VOL_BASE && idx < IDX_VOL_BASE + NVOL);
   // Shadow of the protection enables, seen only through bus writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_r <= SP_CFG_RST[2:1];
      end else if (acc && pwrite && idx == IDX_SP_CFG) begin
         sp_r <= pwdata[2:1];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // Properties
   // ==========================================
   property p_limit;
      sp_r[1] && (short_det & drv_power_on) != '0 |=>
         (drv_limit & $past(short_det & drv_power_on))
            == $past(short_det & drv_power_on);
   endproperty
   a_limit: assert property (p_limit) else $error("limit missing");
   property p_nolimit;
      !sp_r[1] |=> drv_limit == '0;
   endproperty
   a_nolimit: assert property (p_nolimit) else $error("limit stray");
   property p_autooff;
      sp_r == 2'b11 && (short_det & drv_power_on) != '0 |=>
         (drv_power_on & $past(short_det & drv_power_on)) == '0;
   endproperty
   a_autooff: assert property (p_autooff) else $error("no auto off");
   property p_power;
      (drv_power_on & ~$past(drv_power_on)) != '0 |->
         $past(acc && pwrite && idx == IDX_DRV_POWER);
   endproperty
   a_power: assert property (p_power) else $error("power on uncaused");
   property p_irq;
      $fell(irq) |-> $past(ireg) || $past(ireg, 2) || $past(ireg, 3);
   endproperty
   a_irq: assert property (p_irq) else $error("irq fell alone");
   property p_bus;
      psel && penable |-> pready && pslverr == !hit;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer wrong");
   property p_rdata;
      psel && penable && !pwrite |-> prdata[31:8] == '0 && (hit || prdata == '0);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data wrong");
   property p_mute;
      vol_mute[0] |-> vol_atten[9:0] == '0;
   endproperty
   a_mute: assert property (p_mute) else $error("muted gain");
   property p_range;
      vol_atten[9:0] <= 10'd783;
   endproperty
   a_range: assert property (p_range) else $error("gain range");
endmodule

bind output_protect_detect_volume outprot_checker #(.NDRV(NDRV), .NVOL(NVOL))
   outprot_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .short_det(short_det), .drv_power_on(drv_power_on),
   .drv_limit(drv_limit), .vol_atten(vol_atten), .vol_mute(vol_mute),
   .irq(irq));

// ---- testbench/jack_model.sv ----
`timescale 1ns/1ps
module jack_model (
   input wire logic pclk,
   input wire logic plug,
   input wire logic [1:0] kind,
   input wire logic slow,
   input wire logic [3:0] short_in,
   output logic [3:0] short_det,
   output logic jack_sense,
   output logic mic_sense,
   output logic mono_sense
);
   logic [3:0] bounce_r = 4'h0;
   logic plug_r = 1'b0;
   // Contact bounce after each plug change, so debounce is exercised
   always_ff @(posedge pclk) begin
      plug_r <= plug;
      if (slow && plug != plug_r) begin
         bounce_r <= 4'hf;
      end else if (bounce_r != 4'h0) begin
         bounce_r <= bounce_r - 4'h1;
      end
   end
   // Sense contacts are pulled low while nothing is plugged
   assign jack_sense = (bounce_r != 4'h0) ? bounce_r[0] : plug;
   assign mic_sense = plug & (kind == 2'b11);
   assign mono_sense = plug & (kind == 2'b10);
   assign short_det = short_in;
endmodule

// ---- testbench/output_protect_detect_volume_tb.sv ----
`timescale 1ns/1ps
module output_protect_detect_volume_tb
   import outprot_pkg::*;
;
   localparam int NV = 7;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, irq, jack_sense, mic_sense, mono_sense, err;
   logic [3:0] short_det, drv_power_on, drv_limit;
   logic [NV*10-1:0] vol_atten;
   logic [NV-1:0] vol_mute;
   logic plug = 1'b0;
   logic slow = 1'b0;
   logic [1:0] kind = 2'b01;
   logic [3:0] short_in = 4'h0;
   logic [7:0] seed = 8'h0f;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   int vol_m [NV];
   int codes [$] = '{0, 1, 36, 37, 70, 71, 99, 100, 101, 106, 110, 116,
      117, 118, 127};
   output_protect_detect_volume #(.NDRV(4), .NVOL(NV), .TICK_CYCLES(4))
      output_protect_detect_volume_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .short_det(short_det), .drv_power_on(drv_power_on),
      .drv_limit(drv_limit), .jack_sense(jack_sense), .mic_sense(mic_sense),
      .mono_sense(mono_sense), .vol_atten(vol_atten), .vol_mute(vol_mute),
      .irq(irq));
   jack_model jack_model_inst (.pclk(pclk), .plug(plug), .kind(kind),
      .slow(slow), .short_in(short_in), .short_det(short_det),
      .jack_sense(jack_sense), .mic_sense(mic_sense),
      .mono_sense(mono_sense));
   // ==========================================
   // Clock, timeout and helpers
   // ==========================================
   always #20 pclk = ~pclk;
   // Cut a hang short well past the expected run length
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures++;
         print_verdict();
      end
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Attenuation in 0.1 dB; linear stretches, corners by table
   function automatic int exp_atten(input int c);
      if (c >= 118) return 0;
      if (c <= 36) return 5 * c;
      if (c <= 70) return 5 * c + 1;
      case (c)
         71: return 357;
         99: return 500;
         100: return 503;
         101: return 510;
         106: return 537;
         110: return 583;
         116: return 722;
         117: return 783;
         default: return -1;
      endcase
   endfunction
   task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [9:0] i,
      input logic [31:0] e);
      apb(1'b0, i, 32'h0);
      check(nm, e, rd);
   endtask
   task automatic wait_irq();
      for (int n = 0; n < 300 && irq !== 1'b1; n++) @(posedge pclk);
      check("irq", 32'h1, 32'(irq));
   endtask
   task automatic print_verdict();
      $display("Counts: checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rchk("out_cfg", IDX_OUT_CFG, {24'h0, OUT_CFG_RST});
      rchk("jack_cfg", IDX_JACK_CFG, {24'h0, JACK_CFG_RST});
      rchk("sp_cfg", IDX_SP_CFG, {24'h0, SP_CFG_RST});
      rchk("int_mask", IDX_INT_MASK, {28'h0, INT_MASK_RST});
      rchk("drv_power", IDX_DRV_POWER, 32'h0);
      apb(1'b0, 10'h070, 32'h0);
      check("unmapped err", 32'h1, 32'(err));
      check("unmapped data", 32'h0, rd);
      $display("Test reset done");
      // Corner codes, then random ones with junk in the upper bits
      repeat (8) begin
         seed = lfsr(seed);
         codes.push_back(int'(seed[5:0]));
      end
      foreach (codes[i]) begin
         seed = lfsr(seed);
         apb(1'b1, 10'(IDX_VOL_BASE + i % NV), {16'h0, seed, 1'b0,
            7'(codes[i])});
         vol_m[i % NV] = codes[i];
         repeat (NV + 2) @(posedge pclk);
         for (int j = 0; j < NV; j++) begin
            check("atten", 32'(exp_atten(vol_m[j])),
               32'(vol_atten[j*10 +: 10]));
            check("mute", 32'(vol_m[j] >= 118), 32'(vol_mute[j]));
         end
         rchk("vol", 10'(IDX_VOL_BASE + i % NV), 32'(codes[i]));
      end
      $display("Test volume done");
      // Default protection limits only; irq masked then unmasked
      apb(1'b1, IDX_DRV_POWER, 32'hf);
      short_in <= 4'h2;
      repeat (3) @(posedge pclk);
      check("limit", 32'h2, 32'(drv_limit));
      check("power", 32'hf, 32'(drv_power_on));
      check("irq masked", 32'h0, 32'(irq));
      rchk("sc_status", IDX_SC_STATUS, 32'h02);
      apb(1'b1, IDX_INT_MASK, 32'hf);
      wait_irq();
      apb(1'b1, IDX_SP_CFG, 32'h0);
      repeat (2) @(posedge pclk);
      check("limit off", 32'h0, 32'(drv_limit));
      short_in <= 4'h0;
      apb(1'b1, IDX_SP_CFG, 32'h4);
      rchk("int_status", IDX_INT_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      check("irq clear", 32'h0, 32'(irq));
      $display("Test short limit done");
      // Auto power-down holds until an off then on write
      apb(1'b1, IDX_SP_CFG, 32'h6);
      short_in <= 4'h4;
      repeat (3) @(posedge pclk);
      check("auto off", 32'hb, 32'(drv_power_on));
      rchk("sc_status", IDX_SC_STATUS, 32'h40);
      short_in <= 4'h0;
      rchk("int_status", IDX_INT_STATUS, 32'h3);
      apb(1'b1, IDX_DRV_POWER, 32'hf);
      repeat (2) @(posedge pclk);
      check("still off", 32'hb, 32'(drv_power_on));
      apb(1'b1, IDX_DRV_POWER, 32'hb);
      apb(1'b1, IDX_DRV_POWER, 32'hf);
      repeat (2) @(posedge pclk);
      check("back on", 32'hf, 32'(drv_power_on));
      rchk("sc_status", IDX_SC_STATUS, 32'h0);
      $display("Test auto shutdown done");
      // Plug types in capless and AC-coupled wiring, with bounce
      apb(1'b1, IDX_JACK_CFG, 32'h1);
      apb(1'b1, IDX_HS_STATUS, 32'h80);
      slow <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, IDX_OUT_CFG, 32'(m) << 6);
         for (int t = 1; t < 4; t++) begin
            kind <= 2'(t);
            plug <= 1'b1;
            wait_irq();
            rchk("insert", IDX_INT_STATUS, 32'h4);
            rchk("hs", IDX_HS_STATUS, 32'h90 | (t << 5) | (m << 3));
            plug <= 1'b0;
            wait_irq();
            rchk("remove", IDX_INT_STATUS, 32'h8);
            rchk("hs off", IDX_HS_STATUS, 32'h80);
         end
      end
      $display("Test jack done");
      print_verdict();
   end
endmodule
